// ---- src/cssc_top.sv ----
// Clock source selection, start-up timing and clock domain gating
//
// Contract
// - Decode clock source: 1xxx crystal, 0110/0111 low-freq, 0010 RC, 0000 ext.
// - A fuse bit stored as one is unprogrammed, zero is programmed.
// - Wake from sleep counts selected-clock cycles before execution.
// - Reset start adds a watchdog-oscillator timed delay after oscillator start.
// - Reset delay counter offers 4096 or 65536 watchdog cycles.
// - Shipped fuses: code 0010, start-up 10, divide-by-eight programmed.
// - Crystal range comes from upper three clock-select bits.
// - Crystal, low bit 0, start 00/01/10: 258/258/1K, 14+4.1ms/14+65ms/14.
// - Low bit 0 start 11: 1K, 14+4.1ms; bit 1 start 00: 1K, 14+65ms.
// - Low bit 1 start 01/10/11: 16K wake, resets 14, 14+4.1ms, 14+65ms.
// - Halting the core clock stops all core operations.
// - Flash interface clock follows the core clock.
// - Asynchronous timer clock keeps running while the device sleeps.
// - Converter has its own clock that may run while core sleeps.
// - Serial start detection stays armed asynchronously with peripheral clock off.
// - Some external interrupts are detected asynchronously with peripheral clock off.
// - RC oscillator: 6-clock wake, resets 14, 14+4.1ms, 14+65ms.
// - Low-frequency crystal codes 0110/0111 give 1K or 32K wake start-up.
// - External clock 0000: 6-clock wake, reset delays as RC oscillator.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module cssc_top
    import cssc_pkg::*;
#(
    parameter logic [16:0] XTAL_16K_CYC = 17'h04000,
    parameter logic [16:0] LF_32K_CYC = 17'h08000,
    parameter logic [16:0] WDT_LONG_CYC = 17'h10000
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic sel_osc_i,
    input wire logic wdt_osc_i,
    input wire logic wake_i,
    output logic exec_o,
    output logic core_clk_en_o,
    output logic flash_clk_en_o,
    output logic periph_clk_en_o,
    output logic converter_clk_en_o,
    output logic async_timer_clk_en_o,
    output logic async_detect_en_o,
    output logic div8_o,
    output logic [2:0] xtal_range_o,
    output logic [1:0] clk_src_o,
    output logic cfg_invalid_o
);
    cssc_state_t state;
    cssc_state_t next_state;
    logic [6:0] fuse = FUSE_RST;
    logic [6:0] act_fuse;
    logic [3:0] slp;
    logic from_reset;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic osc_rise;
    logic wdt_rise;
    logic wake_rise;
    cssc_dec_t cur_dec;
    cssc_dec_t act_dec;
    cssc_dec_t sel_dec;
    logic wr_fuse;
    logic wr_slp;
    logic sleep_req;
    logic [7:0] stat_word;
    logic [7:0] next_rdata;
    logic next_periph;
    logic next_conv;
    cssc_cnt_if cnt_bus ();

    // Start-up sequence for one fuse setting; reserved codes come out invalid
    function automatic cssc_dec_t dec_cfg(input logic [6:0] f);
        cssc_dec_t d;
        logic [3:0] ck;
        logic [1:0] su;
        ck = f[FUSE_CLOCK_SOURCE_SELECT_LSB +: 4];
        su = f[FUSE_SUT_LSB +: 2];
        d.valid = 1'b0;
        d.src = SRC_EXT;
        d.osc_cyc = CYC_6;
        d.rst_cyc = CYC_14;
        d.rdly = cssc_rdly_t'(su);
        if (ck[CLOCK_SOURCE_SELECT_XTAL_BIT]) begin
            d.valid = 1'b1;
            d.src = SRC_XTAL;
            case ({ck[0], su})
                3'h0: begin d.osc_cyc = CYC_258; d.rdly = RDLY_SHORT; end
                3'h1: begin d.osc_cyc = CYC_258; d.rdly = RDLY_LONG; end
                3'h2: begin d.osc_cyc = CYC_1K; d.rdly = RDLY_NONE; end
                3'h3: begin d.osc_cyc = CYC_1K; d.rdly = RDLY_SHORT; end
                3'h4: begin d.osc_cyc = CYC_1K; d.rdly = RDLY_LONG; end
                3'h5: begin d.osc_cyc = XTAL_16K_CYC; d.rdly = RDLY_NONE; end
                3'h6: begin d.osc_cyc = XTAL_16K_CYC; d.rdly = RDLY_SHORT; end
                default: begin d.osc_cyc = XTAL_16K_CYC; d.rdly = RDLY_LONG; end
            endcase
        end else if (ck == CLOCK_SOURCE_SELECT_LF_1K || ck == CLOCK_SOURCE_SELECT_LF_32K) begin
            d.valid = (su != SUT_RESERVED);
            d.src = SRC_LF;
            d.osc_cyc = (ck == CLOCK_SOURCE_SELECT_LF_32K) ? LF_32K_CYC : CYC_1K;
            d.rst_cyc = CYC_4;
        end else if (ck == CLOCK_SOURCE_SELECT_RC || ck == CLOCK_SOURCE_SELECT_EXT) begin
            d.valid = (su != SUT_RESERVED);
            d.src = (ck == CLOCK_SOURCE_SELECT_RC) ? SRC_RC : SRC_EXT;
        end
        return d;
    endfunction : dec_cfg

    // Watchdog count for a reset delay choice
    function automatic logic [16:0] wdt_cyc(input cssc_rdly_t r);
        return (r == RDLY_LONG) ? WDT_LONG_CYC : WDT_SHORT_CYC;
    endfunction : wdt_cyc

    // Pin edges; the third stage only feeds edge detection
    assign osc_rise = sync2[0] & ~sync3[0];
    assign wdt_rise = sync2[1] & ~sync3[1];
    assign wake_rise = sync2[2] & ~sync3[2];

    // Fuses are applied only at reset start, so a live rewrite is harmless
    assign cur_dec = dec_cfg(fuse);
    assign act_dec = dec_cfg(act_fuse);
    assign sel_dec = (state == ST_INIT) ? cur_dec : act_dec;

    // Register decode
    assign wr_fuse = wr_i && (addr_i == REG_FUSE);
    assign wr_slp = wr_i && (addr_i == REG_SLEEP);
    assign sleep_req = wr_slp && wdata_i[SLP_REQ_BIT];

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            ST_INIT: begin
                next_state = cur_dec.valid ? ST_OSC : ST_BAD;
            end
            ST_OSC: begin
                if (cnt_bus.done) begin
                    next_state = from_reset ? ST_RCK : ST_RUN;
                end
            end
            ST_RCK: begin
                if (cnt_bus.done) begin
                    next_state = (act_dec.rdly == RDLY_NONE) ?
                                 ST_RUN : ST_WDT;
                end
            end
            ST_WDT: begin
                if (cnt_bus.done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_req) begin
                    next_state = ST_SLP;
                end
            end
            ST_SLP: begin
                if (wake_rise) begin
                    next_state = ST_OSC;
                end
            end
            default: begin
                next_state = ST_BAD;
            end
        endcase
    end

    // Counter reload on entry to each timed phase
    assign cnt_bus.load = ce_i && (next_state != state) &&
                          (next_state == ST_OSC || next_state == ST_RCK ||
                           next_state == ST_WDT);
    assign cnt_bus.load_val = (next_state == ST_OSC) ? sel_dec.osc_cyc :
                              (next_state == ST_RCK) ? sel_dec.rst_cyc :
                              wdt_cyc(sel_dec.rdly);
    assign cnt_bus.tick = (state == ST_WDT) ? wdt_rise : osc_rise;

    cssc_counter u_cnt (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .cb(cnt_bus)
    );

    // Next values of the registered outputs
    assign next_periph = (next_state == ST_RUN) ||
                         (next_state == ST_SLP && slp[SLP_KEEP_IO_BIT]);
    assign next_conv = (next_state == ST_RUN) ||
                       (next_state == ST_SLP && slp[SLP_KEEP_ADC_BIT]);
    assign stat_word = {exec_o, from_reset, act_dec.src,
                        state == ST_BAD, state};
    assign next_rdata = !rd_i ? 8'h00 :
                        (addr_i == REG_FUSE) ? {1'b0, fuse} :
                        (addr_i == REG_SLEEP) ? {4'h0, slp} :
                        (addr_i == REG_STAT) ? stat_word : 8'h00;

    // Pin synchronisers, stage one read only by stage two
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
        end else if (ce_i) begin
            sync1 <= {wake_i, wdt_osc_i, sel_osc_i};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Fuse cells keep their value through reset, like non-volatile bits;
    // resetting them would undo every setting before it could be applied
    always_ff @(posedge mclk_i) begin
        if (ce_i && wr_fuse) begin
            fuse <= wdata_i[FUSE_W-1:0];
        end
    end

    // Sequencer state and software registers
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_INIT;
            act_fuse <= FUSE_RST;
            slp <= SLP_RST;
            from_reset <= 1'b1;
        end else if (ce_i) begin
            state <= next_state;
            if (wr_slp) begin
                slp <= {wdata_i[SLP_W-1:1], 1'b0};
            end
            if (state == ST_INIT) begin
                act_fuse <= fuse;
            end
            if (next_state == ST_RUN) begin
                from_reset <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            exec_o <= 1'b0;
            core_clk_en_o <= 1'b0;
            flash_clk_en_o <= 1'b0;
            periph_clk_en_o <= 1'b0;
            converter_clk_en_o <= 1'b0;
            async_timer_clk_en_o <= 1'b0;
            async_detect_en_o <= 1'b1;
            div8_o <= 1'b0;
            xtal_range_o <= XRANGE_NONE;
            clk_src_o <= SRC_EXT;
            cfg_invalid_o <= 1'b0;
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            exec_o <= (next_state == ST_RUN);
            core_clk_en_o <= (next_state == ST_RUN);
            flash_clk_en_o <= (next_state == ST_RUN);
            periph_clk_en_o <= next_periph;
            converter_clk_en_o <= next_conv;
            async_timer_clk_en_o <= slp[SLP_ASY_EN_BIT];
            async_detect_en_o <= !next_periph;
            div8_o <= !act_fuse[FUSE_DIV8_BIT];
            xtal_range_o <= act_fuse[CLOCK_SOURCE_SELECT_XTAL_BIT] ?
                            act_fuse[FUSE_CLOCK_SOURCE_SELECT_LSB+1 +: 3] : XRANGE_NONE;
            clk_src_o <= act_dec.src;
            cfg_invalid_o <= (next_state == ST_BAD);
            rdata_o <= next_rdata;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence slp_wake;
        state == ST_SLP && ce_i && wake_rise;
    endsequence
    sequence osc_end_reset;
        state == ST_OSC && ce_i && cnt_bus.done && from_reset;
    endsequence
    sequence rck_end_wdt;
        state == ST_RCK && ce_i && cnt_bus.done && act_dec.rdly != RDLY_NONE;
    endsequence

    wake_start_a: assert property (slp_wake |=> state == ST_OSC ##1 !exec_o)
        else $error("wake did not start oscillator count");
    reset_delay_a: assert property (osc_end_reset |=> state == ST_RCK)
        else $error("reset start skipped extra delay");
    wdt_count_a: assert property (rck_end_wdt |=> state == ST_WDT &&
        u_cnt.cnt == wdt_cyc(act_dec.rdly))
        else $error("watchdog delay count wrong");
    exec_hold_a: assert property ($rose(exec_o) |-> $past(cnt_bus.done))
        else $error("execution before start-up ended");
    bad_stuck_a: assert property (state == ST_BAD |=> state == ST_BAD
        ##1 !exec_o && cfg_invalid_o)
        else $error("invalid setting left halt state");
    core_halt_a: assert property (state == ST_SLP && ce_i |=>
        !core_clk_en_o)
        else $error("core clock running in sleep");
    flash_core_a: assert property (flash_clk_en_o == core_clk_en_o)
        else $error("flash clock differs from core clock");
    async_keep_a: assert property (state == ST_SLP && ce_i &&
        slp[SLP_ASY_EN_BIT] |=> async_timer_clk_en_o)
        else $error("timer clock stopped in sleep");
    detect_arm_a: assert property (!periph_clk_en_o |-> async_detect_en_o)
        else $error("async detection not armed");
    rc_decode_a: assert property (state == ST_INIT && ce_i &&
        fuse[3:0] == CLOCK_SOURCE_SELECT_RC && fuse[5:4] != SUT_RESERVED
        |=> u_cnt.cnt == CYC_6)
        else $error("RC wake count not six");
endmodule : cssc_top

// ---- src/cssc_pkg.sv ----
// Package for the clock source and start-up control block
package cssc_pkg;
    // Register port and start-up counter geometry
    localparam int CSSC_AW = 2;
    localparam int CSSC_DW = 8;
    localparam int CSSC_CW = 17;
    // Register offsets
    localparam logic [1:0] REG_FUSE = 2'h0;
    localparam logic [1:0] REG_SLEEP = 2'h1;
    localparam logic [1:0] REG_STAT = 2'h2;
    // Fuse register fields; a stored one means unprogrammed
    localparam int FUSE_CLOCK_SOURCE_SELECT_LSB = 0;
    localparam int FUSE_SUT_LSB = 4;
    localparam int FUSE_DIV8_BIT = 6;
    localparam int FUSE_W = 7;
    localparam logic [6:0] FUSE_RST = 7'h22;
    // Sleep control fields
    localparam int SLP_REQ_BIT = 0;
    localparam int SLP_KEEP_IO_BIT = 1;
    localparam int SLP_KEEP_ADC_BIT = 2;
    localparam int SLP_ASY_EN_BIT = 3;
    localparam int SLP_W = 4;
    localparam logic [3:0] SLP_RST = 4'h8;
    // Status fields
    localparam int STAT_BAD_BIT = 3;
    localparam int STAT_SRC_LSB = 4;
    localparam int STAT_FRST_BIT = 6;
    localparam int STAT_EXEC_BIT = 7;
    // Clock source select codes
    localparam logic [3:0] CLOCK_SOURCE_SELECT_EXT = 4'h0;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_RC = 4'h2;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_LF_1K = 4'h6;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_LF_32K = 4'h7;
    localparam int CLOCK_SOURCE_SELECT_XTAL_BIT = 3;
    localparam logic [1:0] SUT_RESERVED = 2'h3;
    localparam logic [2:0] XRANGE_NONE = 3'h0;
    // Start-up counts in cycles of the counted oscillator
    localparam logic [16:0] CYC_4 = 17'h00004;
    localparam logic [16:0] CYC_6 = 17'h00006;
    localparam logic [16:0] CYC_14 = 17'h0000E;
    localparam logic [16:0] CYC_258 = 17'h00102;
    localparam logic [16:0] CYC_1K = 17'h00400;
    localparam logic [16:0] WDT_SHORT_CYC = 17'h01000;
    localparam logic [16:0] CYC_ZERO = 17'h00000;

    typedef enum logic [1:0] {
        RDLY_NONE = 2'h0,
        RDLY_SHORT = 2'h1,
        RDLY_LONG = 2'h2
    } cssc_rdly_t;

    typedef enum logic [1:0] {
        SRC_XTAL = 2'h0,
        SRC_LF = 2'h1,
        SRC_RC = 2'h2,
        SRC_EXT = 2'h3
    } cssc_src_t;

    typedef struct packed {
        logic valid;
        cssc_src_t src;
        logic [16:0] osc_cyc;
        logic [16:0] rst_cyc;
        cssc_rdly_t rdly;
    } cssc_dec_t;

    // Gray codes along init, start-up, run, sleep
    typedef enum logic [2:0] {
        ST_INIT = 3'h4,
        ST_OSC = 3'h0,
        ST_RCK = 3'h1,
        ST_WDT = 3'h3,
        ST_RUN = 3'h2,
        ST_SLP = 3'h6,
        ST_BAD = 3'h7
    } cssc_state_t;
endpackage : cssc_pkg

// ---- src/cssc_cnt_if.sv ----
// Interface between the sequencer and its start-up counter
`timescale 1ns/1ps
interface cssc_cnt_if;
    logic load;
    logic [16:0] load_val;
    logic tick;
    logic done;
    modport ctl (output load, output load_val, output tick, input done);
    modport cnt (input load, input load_val, input tick, output done);
endinterface : cssc_cnt_if

// ---- src/cssc_counter.sv ----
// Reloadable down counter that times start-up phases
`timescale 1ns/1ps
module cssc_counter
    import cssc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    cssc_cnt_if.cnt cb
);
    logic [16:0] cnt;
    logic [16:0] next_cnt;

    // Reload wins over a tick so a new phase never inherits a stale count
    assign next_cnt = cb.load ? cb.load_val :
                      (cb.tick && cnt != CYC_ZERO) ?
                      17'(cnt - 17'h00001) : cnt;
    assign cb.done = (cnt == CYC_ZERO);

    // Count register, frozen while the clock enable is low
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= CYC_ZERO;
        end else if (ce_i) begin
            cnt <= next_cnt;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    cnt_reload_a: assert property (ce_i && cb.load |=> cnt == $past(cb.load_val))
        else $error("counter did not take reload value");
    cnt_step_a: assert property (ce_i && !cb.load && cb.tick && !cb.done
        |=> cnt == 17'($past(cnt) - 17'h00001))
        else $error("counter did not step by one");
endmodule : cssc_counter

// ---- tb/clock_source_startup_control_tb.sv ----
// Self-checking bench for clock source selection and start-up timing
`timescale 1ns/1ps
module clock_source_startup_control_tb;
    import cssc_pkg::*;
    localparam int P = 4; // Both oscillators run at a quarter of mclk
    localparam int X16 = 16;
    localparam int LF32 = 32;
    localparam int WL = 64;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sel_osc_i = 1'b0;
    logic wdt_osc_i = 1'b0;
    logic wake_i = 1'b0;
    logic [7:0] rdata_o;
    logic exec_o, core_clk_en_o, flash_clk_en_o, periph_clk_en_o;
    logic converter_clk_en_o, async_timer_clk_en_o, async_detect_en_o;
    logic div8_o, cfg_invalid_o;
    logic [2:0] xtal_range_o;
    logic [1:0] clk_src_o;
    logic [1:0] ph = 2'h0;
    int n_fail = 0;
    int n_tests = 0;
    int n_short = 0;

    // Shortened long counts keep the run short
    cssc_top #(.XTAL_16K_CYC(17'h00010), .LF_32K_CYC(17'h00020),
        .WDT_LONG_CYC(17'h00040)) i_dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sel_osc_i(sel_osc_i), .wdt_osc_i(wdt_osc_i), .wake_i(wake_i),
        .exec_o(exec_o), .core_clk_en_o(core_clk_en_o),
        .flash_clk_en_o(flash_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
        .converter_clk_en_o(converter_clk_en_o),
        .async_timer_clk_en_o(async_timer_clk_en_o),
        .async_detect_en_o(async_detect_en_o), .div8_o(div8_o),
        .xtal_range_o(xtal_range_o), .clk_src_o(clk_src_o),
        .cfg_invalid_o(cfg_invalid_o));

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // Slow oscillators; opposite phases so their rising edges never coincide
    always @(posedge mclk_i) begin
        ph <= ph + 2'h1;
        sel_osc_i <= ph[1];
        wdt_osc_i <= ~ph[1];
    end

    task automatic report_and_stop;
        $display("TB: %0d checks, %0d mismatches", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [16:0] exp,
                       input logic [16:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic chk_in(input string what, input int lo, input int hi,
                          input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
                     hi, got);
        end
    endtask : chk_in

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    // Counts cycles to execution; core and flash must stay gated meanwhile
    task automatic wait_exec(output int n);
        logic bad;
        bad = 1'b0;
        n = 0;
        while (exec_o !== 1'b1 && n < 70000) begin
            @(posedge mclk_i);
            #1;
            n++;
            if (exec_o !== 1'b1) begin
                bad = bad | core_clk_en_o | flash_clk_en_o;
            end
        end
        chk("clock gate during start-up", 0, bad);
    endtask : wait_exec

    task automatic pulse_reset;
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
    endtask : pulse_reset

    // Expected wake count, reset part, watchdog count and source
    function automatic bit exp_cfg(input logic [6:0] f, output int osc,
        output int rck, output int wdt, output logic [1:0] src);
        int xo[8] = '{258, 258, 1024, 1024, 1024, X16, X16, X16};
        int xw[8] = '{1, 2, 0, 1, 2, 0, 1, 2};
        int wv[3] = '{0, 4096, WL};
        rck = 14;
        wdt = 0;
        osc = 0;
        src = 2'h3;
        if (f[3]) begin
            src = 2'h0;
            osc = xo[{f[0], f[5:4]}];
            wdt = wv[xw[{f[0], f[5:4]}]];
            return 1'b1;
        end
        if (f[3:1] == 3'h3) begin
            src = 2'h1;
            rck = 4;
            osc = f[0] ? LF32 : 1024;
        end else if (f[3:0] == CLOCK_SOURCE_SELECT_RC || f[3:0] == CLOCK_SOURCE_SELECT_EXT) begin
            src = f[1] ? 2'h2 : 2'h3;
            osc = 6;
        end else begin
            return 1'b0;
        end
        if (f[5:4] == SUT_RESERVED) begin
            return 1'b0;
        end
        wdt = wv[f[5:4]];
        return 1'b1;
    endfunction : exp_cfg

    // Fuse set, reset start, sleep with random gating, wake start
    task automatic run_cfg(input logic [6:0] f);
        int osc, rck, wdt, n, nom;
        logic [1:0] src;
        logic [7:0] d;
        logic [3:0] sv;
        bit ok;
        ok = exp_cfg(f, osc, rck, wdt, src);
        wr(REG_FUSE, {1'b0, f});
        pulse_reset;
        if (!ok) begin
            repeat (300) @(posedge mclk_i);
            #1;
            chk("invalid flag", 1, cfg_invalid_o);
            chk("exec held", 0, exec_o);
            return;
        end
        wait_exec(n);
        nom = (osc + rck + wdt) * P;
        chk_in("reset start", nom - P, nom + 4 * P + 12, n);
        chk("clock source", src, clk_src_o);
        chk("crystal range", f[3] ? f[3:1] : 3'h0, xtal_range_o);
        chk("divide by eight", !f[6], div8_o);
        chk("invalid flag", 0, cfg_invalid_o);
        chk("core clock", 1, core_clk_en_o);
        chk("flash clock", 1, flash_clk_en_o);
        rd(REG_FUSE, d);
        chk("fuse readback", {1'b0, f}, d);
        rd(REG_STAT, d);
        chk("status", {1'b1, src, 1'b0, 3'h2}, {d[7], d[5:0]});
        sv = {3'($urandom), 1'b1};
        wr(REG_SLEEP, {4'h0, sv});
        repeat (3) @(posedge mclk_i);
        #1;
        chk("sleep exec", 0, exec_o);
        chk("sleep core", 0, core_clk_en_o);
        chk("sleep flash", 0, flash_clk_en_o);
        chk("sleep periph", sv[1], periph_clk_en_o);
        chk("sleep converter", sv[2], converter_clk_en_o);
        chk("sleep async timer", sv[3], async_timer_clk_en_o);
        chk("async detect", !sv[1], async_detect_en_o);
        rd(REG_STAT, d);
        chk("sleep state", 3'h6, d[2:0]);
        rd(REG_SLEEP, d);
        chk("sleep reg", {4'h0, sv[3:1], 1'b0}, d);
        @(posedge mclk_i);
        wake_i <= 1'b1;
        wait_exec(n);
        @(posedge mclk_i);
        wake_i <= 1'b0;
        nom = osc * P;
        chk_in("wake start", nom - P, nom + 4 * P + 12, n);
    endtask : run_cfg

    // Watchdog sized above the longest start-up mix the seed can draw
    initial begin
        #(25ns * 120000);
        n_fail++;
        report_and_stop;
    end

    initial begin
        int osc, rck, wdt;
        logic [1:0] src;
        logic [6:0] f;
        logic [7:0] d;
        bit ok;
        void'($urandom(45375));
        repeat (4) @(posedge mclk_i);
        #1;
        chk("reset detect", 1, async_detect_en_o);
        chk("reset source", 3, clk_src_o);
        chk("reset core", 0, core_clk_en_o);
        @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd(REG_FUSE, d);
        chk("fuse default", {1'b0, FUSE_RST}, d);
        rd(REG_SLEEP, d);
        chk("sleep default", {4'h0, SLP_RST}, d);
        wr(2'h3, 8'hFF);
        rd(2'h3, d);
        chk("unmapped read", 0, d);
        // A strobe while the clock enable is low must be ignored
        @(posedge mclk_i);
        ce_i <= 1'b0;
        wr(REG_FUSE, 8'h00);
        @(posedge mclk_i);
        ce_i <= 1'b1;
        rd(REG_FUSE, d);
        chk("frozen fuse write", {1'b0, FUSE_RST}, d);
        run_cfg(FUSE_RST);
        // Range code 100 stands for a ceramic resonator here
        for (int c = 0; c < 16; c++) begin
            do begin
                f = {3'($urandom), c[3:0]};
                ok = exp_cfg(f, osc, rck, wdt, src);
            end while (wdt == 4096 && n_short > 0);
            if (wdt == 4096) begin
                n_short++;
            end
            run_cfg(f);
        end
        report_and_stop;
    end
endmodule : clock_source_startup_control_tb
